// ===== rtl/efpm_cfg.svh
// Constants for the encoder frequency and period meter
`ifndef EFPM_CFG_SVH
`define EFPM_CFG_SVH
// Register word indices, compared with address bits 4:2
`define EFPM_OFS_WIN 3'h0
`define EFPM_OFS_WAIT 3'h1
`define EFPM_OFS_FSC 3'h2
`define EFPM_OFS_PSC 3'h3
`define EFPM_OFS_RATE 3'h4
`define EFPM_OFS_PER 3'h5
`define EFPM_OFS_STAT 3'h6
// Reset values
`define EFPM_WIN_US_RST 32'h0000_2710
`define EFPM_WAIT_US_RST 32'h000F_4240
`define EFPM_FSC_RST 32'h0000_0064
`define EFPM_PSC_RST 32'h0000_000A
// Scaling codes and divisors
`define EFPM_FSC_HZ 32'h0000_0001
`define EFPM_PSC_100 32'h0000_0064
`define EFPM_PSC_500 32'h0000_01F4
`define EFPM_PDIV_100 32'h0000_000A
`define EFPM_PDIV_500 32'h0000_0032
`define EFPM_K_HZ 64'h0000_0000_05F5_E100
`define EFPM_K_CHZ 64'h0000_0002_540B_E400
`define EFPM_PER_MAX 32'h8000_0000
// Timing
`define EFPM_CLK_NS 32'h0000_000A
`define EFPM_US_NS 32'h0000_03E8
`define EFPM_US_CYC (`EFPM_US_NS / `EFPM_CLK_NS)
`define EFPM_PER_TMO_S 64'h0000_0000_0000_0015
`define EFPM_PER_TMO_CYC (`EFPM_PER_TMO_S * 64'h3B9A_CA00 / 64'hA)
`endif

// ===== rtl/efpm_pkg.sv
// Types for the encoder frequency and period meter
`default_nettype none
package efpm_pkg;
    typedef enum logic [0:0] {
        EFPM_IDLE = 1'b0,
        EFPM_RUN = 1'b1
    } efpm_state_t;
endpackage
`default_nettype wire

// ===== rtl/efpm_meter.sv
// Encoder track A frequency and period meter with Avalon-MM registers
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "efpm_cfg.svh"
// Function
// R1: rate equals complete periods in window divided by measured interval
// R2: period counting starts at first rising edge after window opens
// R3: interval runs from first rising to last falling edge in window
// R4: rate interval timed on a 10 ns timebase
// R5: window length configurable, resets to 10 ms
// R6: rate unit 0.01 Hz by default, value one selects 1 Hz
// R7: rate measurement runs free, unrelated to host cycle
// R8: counter gate or external reset never disturb rate measurement
// R9: host sets window to at least twice the slowest period
// R10: window without complete period opens another until wait time ends
// R11: while waiting, rate output holds last valid result
// R12: wait time expiry discards measurement and zeroes rate output
// R13: period measured between consecutive rising edges on 10 ns timebase
// R14: latest completed period published as separate period value
// R15: period unit 10 ns default, 100 and 500 select 100/500 ns
// R16: without new period, period output keeps last valid value
// R17: period timing spans host cycles, output updates on each new period
// R18: no period for 21 s sets period output to 2147483648
// R19: track A synchronised, each edge seen once and timestamped
// R20: outputs reset to zero and both measurements restart on reset
module efpm_meter
    import efpm_pkg::*;
#(
    parameter logic [31:0] PER_TMO_CYC = 32'(`EFPM_PER_TMO_CYC)
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Encoder track A pin
    input wire logic trk_a,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Process values
    output logic [31:0] rate_value,
    output logic [31:0] period_value
);

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Synchroniser and edge detect
    logic [2:0] a_s_q;
    logic [2:0] vld_q;
    logic rise;
    logic fall;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            a_s_q <= 3'h0;
            vld_q <= 3'h0;
        end else begin
            a_s_q <= {a_s_q[1:0], trk_a}; // R19
            vld_q <= {vld_q[1:0], 1'b1};
        end
    end
    // Edges gated until the history holds real pin samples
    assign rise = a_s_q[1] & ~a_s_q[2] & vld_q[2]; // R19
    assign fall = ~a_s_q[1] & a_s_q[2] & vld_q[2]; // R19

    ////////////////////////////////////////////////////////////////////////
    // Timebase, microsecond tick
    logic [31:0] ts_q;
    logic [6:0] us_q;
    logic tick;
    assign tick = (us_q == 7'(`EFPM_US_CYC - 32'h1));
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ts_q <= 32'h0;
            us_q <= 7'h0;
        end else begin
            ts_q <= ts_q + 32'h1; // R4
            us_q <= tick ? 7'h0 : us_q + 7'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0] win_us_q;
    logic [31:0] wait_us_q;
    logic [31:0] fsc_q;
    logic [31:0] psc_q;
    logic [31:0] rate_q;
    logic [31:0] period_q;
    logic [31:0] rdmux;
    logic [2:0] widx;
    logic wr_go;
    logic stat_rv_q;
    assign widx = address[4:2];
    assign wr_go = write & ~waitrequest;
    assign rdmux = (widx == `EFPM_OFS_WIN) ? win_us_q :
        (widx == `EFPM_OFS_WAIT) ? wait_us_q :
        (widx == `EFPM_OFS_FSC) ? fsc_q :
        (widx == `EFPM_OFS_PSC) ? psc_q :
        (widx == `EFPM_OFS_RATE) ? rate_q :
        (widx == `EFPM_OFS_PER) ? period_q :
        (widx == `EFPM_OFS_STAT) ? {31'h0, stat_rv_q} : 32'h0;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0;
            win_us_q <= `EFPM_WIN_US_RST; // R5
            wait_us_q <= `EFPM_WAIT_US_RST;
            fsc_q <= `EFPM_FSC_RST; // R6
            psc_q <= `EFPM_PSC_RST; // R15
        end else begin
            waitrequest <= ~((read | write) & waitrequest);
            if (read & waitrequest) begin
                readdata <= rdmux;
            end
            if (wr_go & (widx == `EFPM_OFS_WIN)) begin
                win_us_q <= be_merge(win_us_q, writedata, byteenable); // R5
            end
            if (wr_go & (widx == `EFPM_OFS_WAIT)) begin
                wait_us_q <= be_merge(wait_us_q, writedata, byteenable);
            end
            if (wr_go & (widx == `EFPM_OFS_FSC)) begin
                fsc_q <= be_merge(fsc_q, writedata, byteenable); // R6
            end
            if (wr_go & (widx == `EFPM_OFS_PSC)) begin
                psc_q <= be_merge(psc_q, writedata, byteenable); // R15
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rate window, free running, no gate or counter reset input
    efpm_state_t st_q;
    logic [31:0] win_cnt_q;
    logic [31:0] wait_cnt_q;
    logic first_q;
    logic [23:0] n_q;
    logic [31:0] t_first_q;
    logic [31:0] t_last_q;
    logic win_end;
    logic got;
    logic expire;
    logic div_start;
    assign win_end = (st_q == EFPM_RUN) & tick &
        (win_cnt_q + 32'h1 >= win_us_q); // R5 R7 R8
    assign got = (n_q != 24'h0);
    assign expire = win_end & ~got & (wait_cnt_q >= wait_us_q); // R12
    assign div_start = win_end & got & (t_last_q != t_first_q); // R1
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_q <= EFPM_IDLE; // R20
            win_cnt_q <= 32'h0;
            wait_cnt_q <= 32'h0;
            first_q <= 1'b0;
            n_q <= 24'h0;
            t_first_q <= 32'h0;
            t_last_q <= 32'h0;
        end else begin
            case (st_q)
                EFPM_IDLE: begin
                    st_q <= EFPM_RUN;
                end
                EFPM_RUN: begin
                    if (win_end) begin
                        win_cnt_q <= 32'h0;
                        first_q <= rise; // R2
                        n_q <= 24'h0;
                        t_first_q <= ts_q;
                        if (got | expire) begin
                            wait_cnt_q <= 32'h0; // R10 R12
                        end else begin
                            wait_cnt_q <= wait_cnt_q + 32'h1; // R10
                        end
                    end else begin
                        if (tick) begin
                            win_cnt_q <= win_cnt_q + 32'h1;
                            wait_cnt_q <= wait_cnt_q + 32'h1; // R10
                        end
                        if (rise & ~first_q) begin
                            first_q <= 1'b1; // R2
                            t_first_q <= ts_q; // R3
                        end
                        if (fall & first_q) begin
                            n_q <= n_q + 24'h1; // R1
                            t_last_q <= ts_q; // R3
                        end
                    end
                end
                default: begin
                    st_q <= EFPM_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequential divider for the rate
    logic div_busy_q;
    logic [5:0] div_cnt_q;
    logic [63:0] quo_q;
    logic [32:0] rem_q;
    logic [31:0] dvs_q;
    logic [32:0] rem_sh;
    logic rem_ge;
    logic [32:0] rem_d;
    logic [63:0] quo_d;
    logic div_last;
    logic [63:0] rate_k;
    assign rate_k = (fsc_q == `EFPM_FSC_HZ) ? `EFPM_K_HZ : `EFPM_K_CHZ; // R6
    assign rem_sh = {rem_q[31:0], quo_q[63]};
    assign rem_ge = (rem_sh >= {1'b0, dvs_q});
    assign rem_d = rem_ge ? rem_sh - {1'b0, dvs_q} : rem_sh;
    assign quo_d = {quo_q[62:0], rem_ge};
    assign div_last = div_busy_q & (div_cnt_q == 6'h3F);
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            div_busy_q <= 1'b0;
            div_cnt_q <= 6'h0;
            quo_q <= 64'h0;
            rem_q <= 33'h0;
            dvs_q <= 32'h0;
            rate_q <= 32'h0; // R20
            stat_rv_q <= 1'b0;
        end else begin
            if (div_start & ~div_busy_q) begin
                div_busy_q <= 1'b1;
                div_cnt_q <= 6'h0;
                quo_q <= 64'(n_q) * rate_k; // R1 R6
                rem_q <= 33'h0;
                dvs_q <= t_last_q - t_first_q; // R3 R4
            end else if (div_busy_q) begin
                div_cnt_q <= div_cnt_q + 6'h1;
                quo_q <= quo_d;
                rem_q <= rem_d;
                if (div_last) begin
                    div_busy_q <= 1'b0;
                end
            end
            if (div_last) begin // R11
                rate_q <= (quo_d[63:32] != 32'h0) ? 32'hFFFF_FFFF :
                    quo_d[31:0]; // R1
                stat_rv_q <= 1'b1;
            end else if (expire) begin
                rate_q <= 32'h0; // R12
                stat_rv_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Period measurement
    logic have_q;
    logic [31:0] per_cnt_q;
    logic [31:0] per_scaled;
    logic per_pub;
    assign per_scaled = (psc_q == `EFPM_PSC_100) ?
        per_cnt_q / `EFPM_PDIV_100 : (psc_q == `EFPM_PSC_500) ?
        per_cnt_q / `EFPM_PDIV_500 : per_cnt_q; // R15
    assign per_pub = rise & have_q & (per_cnt_q < PER_TMO_CYC);
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            have_q <= 1'b0; // R20
            per_cnt_q <= 32'h0;
            period_q <= 32'h0; // R20
        end else if (rise) begin
            have_q <= 1'b1;
            per_cnt_q <= 32'h1; // R13 R17
            if (per_pub) begin
                period_q <= per_scaled; // R14 R17
            end
        end else if (have_q) begin
            if (per_cnt_q >= PER_TMO_CYC) begin
                have_q <= 1'b0;
                period_q <= `EFPM_PER_MAX; // R18
            end else begin
                per_cnt_q <= per_cnt_q + 32'h1; // R13 R16
            end
        end
    end
    assign rate_value = rate_q;
    assign period_value = period_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    edge_once_a: assert property (rise |=> !rise) // R19
        else $error("track A rise seen twice");
    rst_zero_a: assert property ($past(reset) |->
        rate_q == 32'h0 && period_q == 32'h0) // R20
        else $error("outputs not zero after reset");
    win_dflt_a: assert property ($past(reset) |->
        win_us_q == `EFPM_WIN_US_RST) // R5
        else $error("window reset value wrong");
    div_len_a: assert property (div_start && !div_busy_q |->
        ##64 div_last) // R1
        else $error("rate division length wrong");
    rate_k_a: assert property (div_start && !div_busy_q &&
        fsc_q == `EFPM_FSC_HZ |=> quo_q == 64'($past(n_q)) * `EFPM_K_HZ) // R6
        else $error("rate scaling wrong");
    rate_hold_a: assert property (!div_last && !expire
        |=> $stable(rate_q)) // R11
        else $error("rate changed without result");
    rate_zero_a: assert property (expire && !div_last
        |=> rate_q == 32'h0) // R12
        else $error("rate not zeroed on wait expiry");
    per_pub_a: assert property (per_pub && psc_q == `EFPM_PSC_500
        |=> period_q == $past(per_cnt_q) / `EFPM_PDIV_500) // R15
        else $error("period scaling wrong");
    per_raw_a: assert property (per_pub && psc_q == `EFPM_PSC_RST
        |=> period_q == $past(per_cnt_q)) // R13
        else $error("period value wrong");
    per_hold_a: assert property (!rise && per_cnt_q < PER_TMO_CYC
        |=> $stable(period_q)) // R16
        else $error("period changed without edge");
    per_tmo_a: assert property (!rise && have_q &&
        per_cnt_q >= PER_TMO_CYC |=> period_q == `EFPM_PER_MAX) // R18
        else $error("period timeout value wrong");

    rate_upd_c: cover property (div_last);
    rate_exp_c: cover property (expire);
    per_pub_c: cover property (per_pub);
    per_tmo_c: cover property (have_q && per_cnt_q >= PER_TMO_CYC);

endmodule
`default_nettype wire

// ===== test/efpm_enc_model.sv
// Encoder track A model with settable period and high time
`timescale 1ns/10ps
`default_nettype none
module efpm_enc_model (
    // Clock
    input wire logic mclk,
    // Control from the bench
    input wire logic en,
    input wire logic [15:0] per,
    input wire logic [15:0] hi,
    // Track A pin
    output logic trk_a
);
    logic [15:0] cnt_q;

    // Stopped encoder rests low, running one gives per-cycle periods
    always_ff @(posedge mclk) begin
        if (!en) begin
            cnt_q <= 16'h0000;
            trk_a <= 1'b0;
        end else begin
            trk_a <= (cnt_q < hi);
            cnt_q <= (cnt_q == per - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ===== test/efpm_meter_tb.sv
// Self-checking bench for the encoder frequency and period meter
`timescale 1ns/10ps
`default_nettype none
`include "efpm_cfg.svh"
`define CHK(a, e) begin \
    cmp_count++; \
    if ((a) !== (e)) begin \
        n_errors++; \
        $display("Error at %0t: got %h want %h", $time, (a), (e)); \
    end \
end
module efpm_meter_tb;
    logic mclk, reset, trk_a, read, write, enc_en;
    logic [4:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, rate_value, period_value, q, r1;
    logic waitrequest;
    logic [15:0] per, hi;
    int n_errors = 0;
    int cmp_count = 0;
    logic [31:0] dflt [8] = '{32'h0000_2710, `EFPM_WAIT_US_RST, 32'h0000_0064,
        32'h0000_000A, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] psc_in [4] = '{32'hA, 32'h64, 32'h1F4, 32'h7};
    logic [31:0] per_exp [4] = '{32'h64, 32'hA, 32'h2, 32'h64};

    efpm_meter #(.PER_TMO_CYC(32'h0000_07D0)) DUT (
        .mclk(mclk), .reset(reset), .trk_a(trk_a), .address(address),
        .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .rate_value(rate_value),
        .period_value(period_value)
    );

    efpm_enc_model enc (
        .mclk(mclk), .en(enc_en), .per(per), .hi(hi), .trk_a(trk_a)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [2:0] idx,
            input logic [31:0] d, input logic [3:0] be,
            output logic [31:0] rd);
        address <= {idx, 2'b00};
        write <= w;
        read <= ~w;
        writedata <= d;
        byteenable <= be;
        do begin
            @(posedge mclk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic check_defaults();
        logic [31:0] v;
        `CHK(rate_value, 32'h0)
        `CHK(period_value, 32'h0)
        `CHK(waitrequest, 1'b1)
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 3'(i), 32'h0, 4'hF, v);
            `CHK(v, dflt[i])
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        repeat (60000) @(posedge mclk);
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        results();
    end

    initial begin
        reset = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 5'h00;
        byteenable = 4'h0;
        writedata = 32'h0;
        enc_en = 1'b0;
        per = 16'h0064;
        hi = 16'h0063;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        check_defaults();
        // Window 20 us, byte lanes 0 and 1 only
        bus(1'b1, 3'h0, 32'hFFFF_0014, 4'h3, q);
        bus(1'b0, 3'h0, 32'h0, 4'hF, q);
        `CHK(q, 32'h0000_0014)
        bus(1'b1, 3'h1, 32'h0000_0064, 4'hF, q);
        bus(1'b1, 3'h2, 32'h0000_0001, 4'hF, q);
        enc_en <= 1'b1;
        // Period scaling rows
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 3'h3, psc_in[i], 4'hF, q);
            repeat (300) @(posedge mclk);
            `CHK(period_value, per_exp[i])
            bus(1'b0, 3'h5, 32'h0, 4'hF, q);
            `CHK(q, per_exp[i])
        end
        // Rate near 1 MHz in Hz, then in 0.01 Hz
        repeat (6000) @(posedge mclk);
        `CHK(rate_value > 32'hF4240 && rate_value <= 32'hF4498, 1'b1)
        bus(1'b0, 3'h6, 32'h0, 4'hF, q);
        `CHK(q, 32'h0000_0001)
        bus(1'b1, 3'h2, 32'h0000_0064, 4'hF, q);
        repeat (4200) @(posedge mclk);
        `CHK(rate_value > 32'h5F5E100 && rate_value <= 32'h5F6CB60, 1'b1)
        // Encoder stops: hold, timeouts
        enc_en <= 1'b0;
        repeat (1000) @(posedge mclk);
        `CHK(period_value, 32'h0000_0064)
        repeat (1500) @(posedge mclk);
        r1 = rate_value;
        `CHK(period_value, 32'h8000_0000)
        `CHK(r1 > 32'h5F5E100, 1'b1)
        repeat (5500) @(posedge mclk);
        `CHK(rate_value, r1)
        repeat (8000) @(posedge mclk);
        `CHK(rate_value, 32'h0)
        bus(1'b0, 3'h6, 32'h0, 4'hF, q);
        `CHK(q, 32'h0)
        enc_en <= 1'b1;
        repeat (400) @(posedge mclk);
        `CHK(period_value, 32'h0000_0064)
        // Second reset in mid-run
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        check_defaults();
        results();
    end
endmodule
`default_nettype wire
